// File: rtl/wfs_regs.vh
// Register map, field positions and reset values of the fall, shutdown and steering block
// Behaviour
// - Seven falling source enables, bits six to zero
// - Disabled falling source starts no falling event; a phase delay already running still fires
// - Edge mode: high-to-low, then phase delay
// - Level mode: low level falls at once
// - Bit seven shows shutdown state
// - B/D override: one, zero, tristate, inactive
// - Four shutdown sources, active when low
// - Disabled shutdown source never causes shutdown
// - Static data bits seven to four
// - Steer bit one: waveform with polarity
// - Steer bit zero: static data level
// - Auto-restart clears shutdown on a rising event when sources idle
// - Without auto-restart, software clears shutdown
// - Six-bit falling phase delay in clocks
`ifndef WFS_REGS_VH
`define WFS_REGS_VH
`define WFS_OFF_FALL_EN    12'h000
`define WFS_OFF_FALL_MODE  12'h004
`define WFS_OFF_SD_CTRL    12'h008
`define WFS_OFF_SD_SRC     12'h00c
`define WFS_OFF_STEER      12'h010
`define WFS_OFF_PHASE      12'h014
`define WFS_OFF_POLARITY   12'h018
`define WFS_OFF_INT_STAT   12'h01c
`define WFS_OFF_INT_MASK   12'h020
`define WFS_FALL_MASK      8'h7f
`define WFS_SD_CTRL_MASK   8'hfc
`define WFS_SD_SRC_MASK    8'h0f
`define WFS_PHASE_MASK     8'h3f
`define WFS_POL_MASK       8'h0f
`define WFS_INT_MASK_BITS  8'h03
`define WFS_SD_ACTIVE_BIT  7
`define WFS_AUTO_RST_BIT   6
`define WFS_OVR_BD_LSB     4
`define WFS_OVR_AC_LSB     2
`define WFS_OVR_ONE        2'b11
`define WFS_OVR_ZERO       2'b10
`define WFS_OVR_TRI        2'b01
`define WFS_OVR_INACTIVE   2'b00
`define WFS_RESET_VALUE    8'h00
`define WFS_INT_SD_BIT     0
`define WFS_INT_FALL_BIT   1
`endif

// File: rtl/wfs_top.v
// Falling event select, auto-shutdown and output steering of the waveform generator
`timescale 1ns/1ps
`include "wfs_regs.vh"
module wfs_top #(
  parameter PHASE_W = 6
) (
  input  wire        MCLK,
  input  wire        RESET,
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output reg         PREADY,
  output reg         PSLVERR,
  input  wire [6:0]  FALL_SRC,
  input  wire [3:0]  SD_SRC,
  input  wire        RISE_EVENT,
  input  wire [3:0]  WAVE_IN,
  output reg         FALL_EVENT,
  output reg  [3:0]  WAVE_OUT,
  output reg  [3:0]  WAVE_OE_N,
  output reg         IRQ
);

  // Control registers
  reg [7:0] fall_en;
  reg [7:0] fall_mode;
  reg [7:0] sd_ctrl;
  reg [7:0] sd_src_en;
  reg [7:0] steer;
  reg [7:0] phase;
  reg [7:0] polarity;
  reg [7:0] int_stat;
  reg [7:0] int_mask;

  // Synchronisers for outside sources
  reg [6:0] fall_s1;
  reg [6:0] fall_s2;
  reg [6:0] fall_prev;
  reg [3:0] sd_s1;
  reg [3:0] sd_s2;

  // Phase delay state
  reg               delay_busy;
  reg [PHASE_W-1:0] delay_cnt;

  wire        apb_access = PSEL & PENABLE;
  wire        apb_wr     = apb_access & PWRITE;
  wire        reg_wr     = apb_wr & ~PREADY;                        // Write lands in the first access cycle
  wire [11:0] addr_word  = PADDR;                                   // Misaligned offsets match no register
  wire [7:0]  wdat       = PWDATA[7:0];

  // Enabled sources only; disabled ones are ignored
  wire [6:0] fall_act   = fall_en[6:0];
  wire [6:0] edge_hits  = fall_act & fall_mode[6:0] & fall_prev & ~fall_s2;
  wire [6:0] level_hits = fall_act & ~fall_mode[6:0] & ~fall_s2;
  wire       edge_any   = |edge_hits;
  wire       level_any  = |level_hits;
  wire       sd_request = |(sd_src_en[3:0] & ~sd_s2);
  wire       sd_active  = sd_ctrl[`WFS_SD_ACTIVE_BIT];
  wire       auto_rst   = sd_ctrl[`WFS_AUTO_RST_BIT];
  wire [1:0] ovr_bd     = sd_ctrl[`WFS_OVR_BD_LSB+1:`WFS_OVR_BD_LSB];
  wire [1:0] ovr_ac     = sd_ctrl[`WFS_OVR_AC_LSB+1:`WFS_OVR_AC_LSB];

  reg       next_fall_event;
  reg [7:0] next_sd_ctrl;
  reg [3:0] next_out;
  reg [3:0] next_oe_n;
  reg [31:0] next_rdata;
  reg       next_err;

  // Known offset test
  function mapped;
    input [11:0] a;
    begin
      mapped = (a <= `WFS_OFF_INT_MASK) && (a[1:0] == 2'b00);
    end
  endfunction

  // One output pin under override code
  function [1:0] override_pin;
    input [1:0] code;
    input       pol;
    begin
      case (code)
        `WFS_OVR_ONE:  override_pin = 2'b10;
        `WFS_OVR_ZERO: override_pin = 2'b00;
        `WFS_OVR_TRI:  override_pin = 2'b01;
        default:       override_pin = {pol, 1'b0};       // Inactive level with polarity
      endcase
    end
  endfunction

  // Shutdown state: sources set it, restart clears it on a rising event
  always @* begin
    next_sd_ctrl = sd_ctrl;
    if (reg_wr && addr_word == `WFS_OFF_SD_CTRL) begin
      next_sd_ctrl = wdat & `WFS_SD_CTRL_MASK;
      next_sd_ctrl[`WFS_SD_ACTIVE_BIT] = sd_active & wdat[`WFS_SD_ACTIVE_BIT];
    end
    if (auto_rst && sd_active && !sd_request && RISE_EVENT) begin
      next_sd_ctrl[`WFS_SD_ACTIVE_BIT] = 1'b0;
    end
    if (sd_request) begin
      next_sd_ctrl[`WFS_SD_ACTIVE_BIT] = 1'b1;
    end
  end

  // Falling event: level at once, edge after the phase count
  always @* begin
    next_fall_event = level_any;
    if (delay_busy && delay_cnt == {PHASE_W{1'b0}}) begin
      next_fall_event = 1'b1;
    end
    if (edge_any && phase[PHASE_W-1:0] == {PHASE_W{1'b0}}) begin
      next_fall_event = 1'b1;
    end
  end

  // Output steering and override
  integer i;
  reg [1:0] ovr;
  always @* begin
    next_out  = 4'h0;
    next_oe_n = 4'h0;
    ovr       = 2'b00;
    for (i = 0; i < 4; i = i + 1) begin
      if (sd_active) begin
        ovr = override_pin((i == 1 || i == 3) ? ovr_bd : ovr_ac, polarity[i]);
        next_out[i]  = ovr[1];
        next_oe_n[i] = ovr[0];
      end else if (steer[i]) begin
        next_out[i] = WAVE_IN[i] ^ polarity[i];
      end else begin
        next_out[i] = steer[i+4];
      end
    end
  end

  // Read mux
  always @* begin
    next_rdata = 32'h0000_0000;
    next_err   = !mapped(addr_word) || PADDR[1:0] != 2'b00;
    case (addr_word)
      `WFS_OFF_FALL_EN:   next_rdata[7:0] = fall_en;
      `WFS_OFF_FALL_MODE: next_rdata[7:0] = fall_mode;
      `WFS_OFF_SD_CTRL:   next_rdata[7:0] = sd_ctrl;
      `WFS_OFF_SD_SRC:    next_rdata[7:0] = sd_src_en;
      `WFS_OFF_STEER:     next_rdata[7:0] = steer;
      `WFS_OFF_PHASE:     next_rdata[7:0] = phase;
      `WFS_OFF_POLARITY:  next_rdata[7:0] = polarity;
      `WFS_OFF_INT_STAT:  next_rdata[7:0] = int_stat;
      `WFS_OFF_INT_MASK:  next_rdata[7:0] = int_mask;
      default:            next_rdata = 32'h0000_0000;
    endcase
  end

  // Synchronisers
  always @(posedge MCLK) begin
    if (RESET) begin
      fall_s1   <= 7'h7f;
      fall_s2   <= 7'h7f;
      fall_prev <= 7'h7f;
      sd_s1     <= 4'hf;
      sd_s2     <= 4'hf;
    end else begin
      fall_s1   <= FALL_SRC;
      fall_s2   <= fall_s1;
      fall_prev <= fall_s2;
      sd_s1     <= SD_SRC;
      sd_s2     <= sd_s1;
    end
  end

  // Phase delay counter; a new edge restarts it
  always @(posedge MCLK) begin
    if (RESET) begin
      delay_busy <= 1'b0;
      delay_cnt  <= {PHASE_W{1'b0}};
    end else if (edge_any && phase[PHASE_W-1:0] != {PHASE_W{1'b0}}) begin
      delay_busy <= 1'b1;
      delay_cnt  <= phase[PHASE_W-1:0] - {{(PHASE_W-1){1'b0}}, 1'b1};
    end else if (delay_busy) begin
      delay_busy <= delay_cnt != {PHASE_W{1'b0}};
      delay_cnt  <= delay_cnt - {{(PHASE_W-1){1'b0}}, 1'b1};
    end
  end

  // Register file: one process per register, each written only in the first access cycle
  // Unimplemented bits are masked at the write so they always read as zero

  // Falling source enables
  always @(posedge MCLK) begin
    if (RESET) begin
      fall_en <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_FALL_EN) begin
      fall_en <= wdat & `WFS_FALL_MASK;
    end
  end

  // Falling source modes
  always @(posedge MCLK) begin
    if (RESET) begin
      fall_mode <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_FALL_MODE) begin
      fall_mode <= wdat & `WFS_FALL_MASK;
    end
  end

  // Shutdown control; status bit follows sources, restart and clears
  always @(posedge MCLK) begin
    if (RESET) begin
      sd_ctrl <= `WFS_RESET_VALUE;
    end else begin
      sd_ctrl <= next_sd_ctrl;
    end
  end

  // Shutdown source enables
  always @(posedge MCLK) begin
    if (RESET) begin
      sd_src_en <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_SD_SRC) begin
      sd_src_en <= wdat & `WFS_SD_SRC_MASK;
    end
  end

  // Static data and steering bits
  always @(posedge MCLK) begin
    if (RESET) begin
      steer <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_STEER) begin
      steer <= wdat;
    end
  end

  // Falling phase delay count
  always @(posedge MCLK) begin
    if (RESET) begin
      phase <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_PHASE) begin
      phase <= wdat & `WFS_PHASE_MASK;
    end
  end

  // Output polarity
  always @(posedge MCLK) begin
    if (RESET) begin
      polarity <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_POLARITY) begin
      polarity <= wdat & `WFS_POL_MASK;
    end
  end

  // Interrupt mask
  always @(posedge MCLK) begin
    if (RESET) begin
      int_mask <= `WFS_RESET_VALUE;
    end else if (reg_wr && addr_word == `WFS_OFF_INT_MASK) begin
      int_mask <= wdat & `WFS_INT_MASK_BITS;
    end
  end

  // Status events and write-one clears
  wire [7:0] int_clr = (reg_wr && addr_word == `WFS_OFF_INT_STAT) ? wdat : 8'h00;
  wire [7:0] int_set = {6'h00, next_fall_event, sd_request & ~sd_active};

  // Sticky status; an event in the clear cycle survives
  always @(posedge MCLK) begin
    if (RESET) begin
      int_stat <= `WFS_RESET_VALUE;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
    end
  end

  // Level interrupt from unmasked status
  always @(posedge MCLK) begin
    if (RESET) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(int_stat & int_mask);
    end
  end

  // Ready one cycle after the access is taken
  always @(posedge MCLK) begin
    if (RESET) begin
      PREADY <= 1'b0;
    end else begin
      PREADY <= apb_access & ~PREADY;
    end
  end

  // Read data stands with ready
  always @(posedge MCLK) begin
    if (RESET) begin
      PRDATA <= 32'h0000_0000;
    end else begin
      PRDATA <= next_rdata;
    end
  end

  // Error response for unmapped or misaligned offsets
  always @(posedge MCLK) begin
    if (RESET) begin
      PSLVERR <= 1'b0;
    end else begin
      PSLVERR <= apb_access & ~PREADY & next_err;
    end
  end

  // Falling event output
  always @(posedge MCLK) begin
    if (RESET) begin
      FALL_EVENT <= 1'b0;
    end else begin
      FALL_EVENT <= next_fall_event;
    end
  end

  // Pin levels
  always @(posedge MCLK) begin
    if (RESET) begin
      WAVE_OUT <= 4'h0;
    end else begin
      WAVE_OUT <= next_out;
    end
  end

  // Pin output enables, low while driven
  always @(posedge MCLK) begin
    if (RESET) begin
      WAVE_OE_N <= 4'h0;
    end else begin
      WAVE_OE_N <= next_oe_n;
    end
  end

endmodule // wfs_top

// File: test/wfs_props.sv
// Port checker for the fall, shutdown and steering block
`timescale 1ns/1ps
module wfs_props (
  input wire logic        MCLK,
  input wire logic        RESET,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        FALL_EVENT,
  input wire logic [3:0]  WAVE_OUT,
  input wire logic [3:0]  WAVE_OE_N,
  input wire logic        IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (RESET);
  ready_pulse_a: assert property (PREADY |=> !PREADY) else $error("ready too long");
  ready_time_a: assert property (PSEL && PENABLE && !PREADY |=> PREADY) else $error("ready late");
  ready_access_a: assert property (PREADY |-> PSEL && PENABLE) else $error("ready outside access");
  err_ready_a: assert property (PSLVERR |-> PREADY) else $error("error without ready");
  upper_zero_a: assert property (PREADY |-> PRDATA[31:8] == 24'h0) else $error("upper read bits set");
  bad_addr_a: assert property (PREADY && (PADDR > 12'h020 || PADDR[1:0] != 2'b00) |-> PSLVERR && PRDATA == 32'h0)
    else $error("unmapped access accepted");
  good_addr_a: assert property (PREADY && PADDR <= 12'h020 && PADDR[1:0] == 2'b00 |-> !PSLVERR)
    else $error("mapped access refused");
  reset_quiet_a: assert property ($fell(RESET) |-> !IRQ && !FALL_EVENT && WAVE_OUT == 4'h0 && WAVE_OE_N == 4'h0)
    else $error("outputs not cleared by reset");
  cover property (PSLVERR);
  cover property (FALL_EVENT);
  cover property (IRQ);
  cover property ($rose(WAVE_OE_N[1]));
endmodule // wfs_props
bind wfs_top wfs_props wfs_props_i (.MCLK(MCLK), .RESET(RESET), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
  .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .FALL_EVENT(FALL_EVENT), .WAVE_OUT(WAVE_OUT),
  .WAVE_OE_N(WAVE_OE_N), .IRQ(IRQ));

// File: test/wfs_gate_drv.sv
// Gate driver inputs seen on the four output pins
`timescale 1ns/1ps
module wfs_gate_drv (
  input  wire logic       clk,
  input  wire logic [3:0] out,
  input  wire logic [3:0] oe_n,
  output logic      [3:0] pin
);
  logic [3:0] last = 4'h0;
  // Last level each pin was driven to
  always @(posedge clk) last <= (out & ~oe_n) | (last & oe_n);
  // A released input drifts away from its last level
  assign pin = (out & ~oe_n) | (~last & oe_n);
endmodule // wfs_gate_drv

// File: test/wfs_tb_top.sv
// Self-checking bench for the fall, shutdown and steering block
`timescale 1ns/1ps
module wfs_tb_top;
  logic        MCLK = 0, RESET = 1, PSEL = 0, PENABLE = 0, PWRITE = 0, RISE_EVENT = 0, PREADY, PSLVERR, FALL_EVENT, IRQ, e;
  logic [11:0] PADDR = 0;
  logic [31:0] PWDATA = 0, PRDATA, q;
  logic [6:0]  FALL_SRC = 7'h7f;
  logic [3:0]  SD_SRC = 4'hf, WAVE_IN = 4'h0, WAVE_OUT, WAVE_OE_N, pin;
  int          error_cnt = 0, checks_done = 0, cyc = 0, seed = 32'hee4ff50f, n, m, rm[9];
  int          msk[9] = '{'h7f, 'h7f, 'h7c, 'h0f, 'hff, 'h3f, 'h0f, 0, 'h03};
  wfs_top wfs_top_i (.*);
  wfs_gate_drv wfs_gate_drv_i (.clk(MCLK), .out(WAVE_OUT), .oe_n(WAVE_OE_N), .pin(pin));
  // Clock and hang guard
  always #2 MCLK = ~MCLK;
  always @(posedge MCLK) if (++cyc == 20000) begin
    error_cnt++;
    stop_test;
  end
  task stop_test;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] x, input logic [31:0] s);
    checks_done++;
    if (s !== x) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", nm, x, s);
    end
  endtask
  // One bus transfer, held until ready
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    PSEL <= 1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge MCLK);
    PENABLE <= 1;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20 && PREADY !== 1'b1) error_cnt++;
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 0;
    PENABLE <= 0;
    @(posedge MCLK);
  endtask
  task wr(input int i, input int d);
    apb(1, 12'(i * 4), d);
    if (i != 7) rm[i] = d & msk[i];
  endtask
  task rd(input int i, input int x);
    apb(0, 12'(i * 4), 0);
    chk("reg", x, q);
    chk("err", 0, e);
  endtask
  // Expected pin levels from the shadow registers
  task outs(input logic sd);
    logic [3:0] eo, eoe;
    logic [1:0] c;
    for (int i = 0; i < 4; i++) begin
      c = i[0] ? rm[2][5:4] : rm[2][3:2];
      eoe[i] = sd && c == 2'b01;
      eo[i] = sd ? (c == 2'b00 ? rm[6][i] : c[1] & c[0]) : (rm[4][i] ? WAVE_IN[i] ^ rm[6][i] : rm[4][i + 4]);
    end
    chk("oe", eoe, WAVE_OE_N);
    chk("pin", eo & ~eoe, pin & ~eoe);
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    RESET <= 0;
    @(posedge MCLK);
    for (int i = 0; i < 9; i++) rd(i, 0);
    apb(0, 12'h024, 0);
    chk("unmapped", 1, e);
    for (int i = 0; i < 9; i++) if (i != 7) begin
      wr(i, $random(seed));
      rd(i, rm[i]);
    end
    // Steering against random waveforms
    for (int k = 0; k < 8; k++) begin
      wr(4, $random(seed));
      wr(6, $random(seed));
      WAVE_IN <= 4'($random(seed));
      repeat (3) @(posedge MCLK);
      outs(0);
    end
    // Shutdown entry, override codes, restart and interrupt
    wr(8, 1);
    for (int k = 0; k < 4; k++) begin
      wr(3, 1 << k);
      wr(2, (k & 1) << 6 | k << 4 | (3 - k) << 2);
      SD_SRC <= ~(4'b1 << (k + 1) % 4);
      repeat (6) @(posedge MCLK);
      rd(2, rm[2]);
      SD_SRC <= ~(4'b1 << k);
      repeat (6) @(posedge MCLK);
      rd(2, rm[2] | 'h80);
      outs(1);
      chk("irq", 1, IRQ);
      SD_SRC <= 4'hf;
      repeat (6) @(posedge MCLK);
      RISE_EVENT <= 1;
      @(posedge MCLK);
      RISE_EVENT <= 0;
      repeat (3) @(posedge MCLK);
      if (!rm[2][6]) begin
        rd(2, rm[2] | 'h80);
        wr(2, rm[2]);
      end
      rd(2, rm[2]);
      outs(0);
      wr(8, 0);
      chk("irq masked", 0, IRQ);
      wr(7, 3);
      wr(8, 1);
      chk("irq cleared", 0, IRQ);
    end
    // Each falling source in level then edge mode
    wr(3, 0);
    for (int j = 0; j < 14; j++) begin
      wr(5, $random(seed));
      wr(0, 1 << j % 7);
      wr(1, (j / 7) << j % 7);
      FALL_SRC <= ~(7'b1 << j % 7);
      m = 0;
      do begin
        @(posedge MCLK);
        m++;
      end while (FALL_EVENT !== 1'b1 && m < 90);
      chk("fall delay", j / 7 ? 4 + rm[5] : 4, m);
      wr(0, 'h7f ^ (1 << j % 7));
      repeat (4) begin
        @(posedge MCLK);
        chk("no fall", 0, FALL_EVENT);
      end
      FALL_SRC <= 7'h7f;
      repeat (4) @(posedge MCLK);
    end
    stop_test;
  end
endmodule // wfs_tb_top
